// >>> logic/seq_pkg.sv
// Shared types and constants of the skip and string-effect sequencer.
// Assumes one 100 MHz clock and an AXI4-Lite master with 8-bit byte addresses.
package seq_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERR = 8'h08;
  localparam logic [7:0] ADDR_REGS = 8'h0C;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MBE_BIT = 1;
  localparam int CTRL_MBS_LSB = 4;
  localparam int CTRL_PCS_LSB = 8;
  localparam int STATUS_CY_BIT = 0;
  localparam int STATUS_CLASS_LSB = 1;
  localparam int STATUS_SKIP_BIT = 4;
  localparam int STATUS_ADJ_LSB = 5;
  localparam int STATUS_PC_LSB = 8;
  localparam int ERR_TADDR_BIT = 0;
  localparam int ERR_FMEM_BIT = 1;
  localparam int ERR_PMEM_BIT = 2;
  localparam int ERR_MEM_ODD_BIT = 3;
  localparam int REGS_HL_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Operand ranges and fixed banks
  // ----------------------------------------------------------------
  localparam logic [7:0] TADDR_MIN = 8'h20;
  localparam logic [7:0] TADDR_MAX = 8'h7F;
  localparam logic [11:0] FMEM_LO_MIN = 12'hFB0;
  localparam logic [11:0] FMEM_LO_MAX = 12'hFBF;
  localparam logic [11:0] FMEM_HI_MIN = 12'hFF0;
  localparam logic [11:0] PMEM_MIN = 12'hFC0;
  localparam logic [7:0] BANK0_TOP = 8'h7F;
  localparam logic [3:0] BANK_LOW = 4'h0;
  localparam logic [3:0] BANK_HIGH = 4'hF;
  localparam logic [2:0] PAIR_XA = 3'h0;
  localparam logic [2:0] PAIR_BC = 3'h1;
  localparam logic [2:0] PAIR_DE = 3'h2;
  localparam logic [2:0] PAIR_HL = 3'h3;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [1:0] SKIP_LONG_EXTRA = 2'h1;
  localparam logic [1:0] SKIP_SHORT_EXTRA = 2'h0;
  localparam logic [1:0] PTR_STEP_EXTRA = 2'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_MOV_A_IMM = 5'h01, OP_MOV_XA_IMM = 5'h02, OP_MOV_HL_IMM = 5'h03,
    OP_MOV_RP2_IMM = 5'h04, OP_ADD_IMMEDIATE_SKIP_ON_CARRY = 5'h05, OP_ADD_WITH_CARRY_OP = 5'h06, OP_SUBTRACT_WITH_BORROW_OP = 5'h07,
    OP_MOV_A_PTR = 5'h08, OP_MOV_XA_RP = 5'h09, OP_MOV_XA_MEM = 5'h0A,
    OP_JUMP = 5'h0B, OP_JUMP_WIDE = 5'h0C, OP_CALL_WIDE = 5'h0D, OP_CALL_COMPACT = 5'h0E,
    OP_CALL_SHORT = 5'h0F, OP_TABLE_CALL = 5'h10, OP_BIT_FAST = 5'h11, OP_BIT_PAIRED = 5'h12
  } op_t;
  typedef enum logic [2:0] {
    PTR_HL = 3'h0, PTR_HL_INC = 3'h1, PTR_HL_DEC = 3'h2, PTR_DE = 3'h3, PTR_DL = 3'h4
  } ptr_t;
  typedef enum logic [2:0] {STR_NONE = 3'b001, STR_ACC = 3'b010, STR_PTR = 3'b100} str_class_t;
  typedef enum logic [2:0] {ADJ_NONE = 3'b001, ADJ_ADD = 3'b010, ADJ_SUB = 3'b100} adj_t;

  typedef struct packed {
    op_t op;
    logic [11:0] addr;
    logic [7:0] imm;
    logic [1:0] bitsel;
    logic [2:0] pair;
    ptr_t ptr;
    logic [7:0] mem_data;
  } instr_t;

  typedef struct packed {
    logic valid;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [3:0] bit_mask;
  } data_ref_t;

  typedef struct packed {
    logic run;
    logic bank_enable_flag;
    logic [3:0] bank_select_value;
    logic [1:0] processor_clock_setting;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{run: 1'b1, bank_enable_flag: 1'b0,
                                   bank_select_value: 4'h0, processor_clock_setting: 2'h0};

  typedef struct packed {
    ctrl_t ctrl;
    logic [11:0] pc;
    logic [7:0][7:0] regs;
    logic carry;
    str_class_t last_class;
    logic skip_next;
    adj_t adj;
    logic [1:0] cnt;
    logic [2:0] div;
    logic [3:0] err;
    data_ref_t dref;
    logic skip_pulse;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  // ----------------------------------------------------------------
  // Instruction properties
  // ----------------------------------------------------------------
  function automatic logic [1:0] instr_bytes(input op_t op);
    unique case (op)
      OP_JUMP, OP_JUMP_WIDE, OP_CALL_WIDE: instr_bytes = 2'h3;
      OP_MOV_XA_IMM, OP_MOV_HL_IMM, OP_MOV_RP2_IMM, OP_MOV_XA_RP, OP_MOV_XA_MEM,
      OP_CALL_COMPACT, OP_CALL_SHORT, OP_BIT_FAST, OP_BIT_PAIRED: instr_bytes = 2'h2;
      default: instr_bytes = 2'h1;
    endcase
  endfunction : instr_bytes

  function automatic str_class_t str_class(input op_t op);
    unique case (op)
      OP_MOV_A_IMM, OP_MOV_XA_IMM: str_class = STR_ACC;
      OP_MOV_HL_IMM: str_class = STR_PTR;
      default: str_class = STR_NONE;
    endcase
  endfunction : str_class

  function automatic logic is_long(input op_t op);
    is_long = (op == OP_JUMP) || (op == OP_JUMP_WIDE) || (op == OP_CALL_WIDE);
  endfunction : is_long

endpackage : seq_pkg

// >>> logic/skip_and_string_effect_sequencer.sv
// Instruction sequencer: string effect, skips, base adjustment, operand decode.
// Assumes program memory presents one decoded instruction per handshake at fetch_pc.
`timescale 1ns/1ns
module skip_and_string_effect_sequencer
  import seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic [11:0] fetch_pc,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire instr_t instr,
  output data_ref_t data_ref,
  output logic carry_flag,
  output logic [3:0] active_data_bank,
  output logic skip_taken
);

  state_t s;
  state_t next_s;
  logic tick;
  logic [2:0] div_mask;
  logic [4:0] sum5;
  logic [7:0] ptr_addr;
  logic [3:0] l_next;
  logic [3:0] hl_bank;
  logic [7:0] mem_addr;
  logic [3:0] mem_bank;
  logic take;
  logic skip_adj;
  logic wr_fire;
  logic [31:0] rd_word;
  logic [3:0] err_set;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = !s.aw_held && !s.bvalid;
  assign wready = !s.w_held && !s.bvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign fetch_pc = s.pc;
  assign data_ref = s.dref;
  assign carry_flag = s.carry;
  assign skip_taken = s.skip_pulse;
  assign active_data_bank = hl_bank;
  assign instr_ready = s.ctrl.run && (s.cnt == 2'h0) && tick;

  assign hl_bank = s.ctrl.bank_enable_flag ? s.ctrl.bank_select_value : BANK_LOW;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    sum5 = 5'h00;
    ptr_addr = 8'h00;
    l_next = 4'h0;
    mem_addr = instr.addr[7:0];
    mem_bank = BANK_LOW;
    skip_adj = 1'b0;
    rd_word = 32'h0000_0000;
    err_set = 4'h0;
    next_s.dref.valid = 1'b0;
    next_s.skip_pulse = 1'b0;
    next_s.div = s.div + 3'h1;
    div_mask = 3'((4'h1 << s.ctrl.processor_clock_setting) - 4'h1);
    tick = (s.div & div_mask) == div_mask;
    if (tick && s.cnt != 2'h0) begin
      next_s.cnt = s.cnt - 2'h1;
    end
    take = instr_valid && instr_ready;
    if (s.ctrl.bank_enable_flag) begin
      mem_bank = s.ctrl.bank_select_value;
    end else if (mem_addr > BANK0_TOP) begin
      mem_bank = BANK_HIGH;
    end

    if (take) begin
      next_s.pc = s.pc + 12'(instr_bytes(instr.op));
      next_s.last_class = str_class(instr.op);
      next_s.skip_next = 1'b0;
      next_s.adj = ADJ_NONE;
      next_s.cnt = instr_bytes(instr.op) - 2'h1;
      if (s.adj == ADJ_ADD) begin
        skip_adj = (instr.op == OP_ADD_IMMEDIATE_SKIP_ON_CARRY) && s.carry;
      end
      if (s.adj == ADJ_SUB) begin
        skip_adj = (instr.op == OP_ADD_IMMEDIATE_SKIP_ON_CARRY) && !s.carry;
      end
      if (s.skip_next || skip_adj) begin
        next_s.skip_pulse = 1'b1;
        next_s.cnt = is_long(instr.op) ? SKIP_LONG_EXTRA : SKIP_SHORT_EXTRA;
      end else if (str_class(instr.op) != STR_NONE && str_class(instr.op) == s.last_class) begin
        next_s.cnt = instr_bytes(instr.op) - 2'h1;
      end else begin
        unique case (instr.op)
          OP_MOV_A_IMM: next_s.regs[PAIR_XA][3:0] = instr.imm[3:0];
          OP_MOV_XA_IMM: next_s.regs[PAIR_XA] = instr.imm;
          OP_MOV_HL_IMM: next_s.regs[PAIR_HL] = instr.imm;
          OP_MOV_RP2_IMM: next_s.regs[instr.pair[0] ? PAIR_DE : PAIR_BC] = instr.imm;
          OP_ADD_IMMEDIATE_SKIP_ON_CARRY: begin
            sum5 = {1'b0, s.regs[PAIR_XA][3:0]} + {1'b0, instr.imm[3:0]};
            next_s.regs[PAIR_XA][3:0] = sum5[3:0];
            next_s.skip_next = sum5[4] && (s.adj == ADJ_NONE);
          end
          OP_ADD_WITH_CARRY_OP: begin
            sum5 = {1'b0, s.regs[PAIR_XA][3:0]} + {1'b0, instr.mem_data[3:0]}
                   + {4'h0, s.carry};
            next_s.regs[PAIR_XA][3:0] = sum5[3:0];
            next_s.carry = sum5[4];
            next_s.adj = ADJ_ADD;
            next_s.dref = '{valid: 1'b1, bank: hl_bank, addr: s.regs[PAIR_HL], bit_mask: 4'hF};
          end
          OP_SUBTRACT_WITH_BORROW_OP: begin
            sum5 = {1'b0, s.regs[PAIR_XA][3:0]} - {1'b0, instr.mem_data[3:0]}
                   - {4'h0, s.carry};
            next_s.regs[PAIR_XA][3:0] = sum5[3:0];
            next_s.carry = sum5[4];
            next_s.adj = ADJ_SUB;
            next_s.dref = '{valid: 1'b1, bank: hl_bank, addr: s.regs[PAIR_HL], bit_mask: 4'hF};
          end
          OP_MOV_A_PTR: begin
            unique case (instr.ptr)
              PTR_DE: ptr_addr = s.regs[PAIR_DE];
              PTR_DL: ptr_addr = {s.regs[PAIR_DE][7:4], s.regs[PAIR_HL][3:0]};
              default: ptr_addr = s.regs[PAIR_HL];
            endcase
            next_s.regs[PAIR_XA][3:0] = instr.mem_data[3:0];
            next_s.dref.valid = 1'b1;
            next_s.dref.addr = ptr_addr;
            next_s.dref.bank = (instr.ptr == PTR_DE || instr.ptr == PTR_DL) ? BANK_LOW : hl_bank;
            next_s.dref.bit_mask = 4'hF;
            if (instr.ptr == PTR_HL_INC || instr.ptr == PTR_HL_DEC) begin
              l_next = (instr.ptr == PTR_HL_INC) ? s.regs[PAIR_HL][3:0] + 4'h1
                                                 : s.regs[PAIR_HL][3:0] - 4'h1;
              next_s.regs[PAIR_HL][3:0] = l_next;
              next_s.skip_next = (instr.ptr == PTR_HL_INC) ? (l_next == 4'h0)
                                                           : (l_next == 4'hF);
              next_s.cnt = PTR_STEP_EXTRA;
            end
          end
          OP_MOV_XA_RP: next_s.regs[PAIR_XA] = s.regs[instr.pair];
          OP_MOV_XA_MEM: begin
            next_s.regs[PAIR_XA] = instr.mem_data;
            next_s.dref = '{valid: 1'b1, bank: mem_bank, addr: mem_addr, bit_mask: 4'hF};
            if (instr.addr[0]) begin
              err_set[ERR_MEM_ODD_BIT] = 1'b1;
            end
          end
          OP_JUMP, OP_JUMP_WIDE, OP_CALL_WIDE, OP_CALL_COMPACT: begin
            next_s.pc = instr.addr;
            next_s.last_class = STR_NONE;
          end
          OP_CALL_SHORT: begin
            next_s.pc = {1'b0, instr.addr[10:0]};
            next_s.last_class = STR_NONE;
          end
          OP_TABLE_CALL: begin
            if (instr.addr[7:0] < TADDR_MIN || instr.addr[7:0] > TADDR_MAX || instr.addr[0]
                || instr.addr[11:8] != 4'h0) begin
              err_set[ERR_TADDR_BIT] = 1'b1;
            end
          end
          OP_BIT_FAST: begin
            if (!((instr.addr >= FMEM_LO_MIN && instr.addr <= FMEM_LO_MAX)
                  || instr.addr >= FMEM_HI_MIN)) begin
              err_set[ERR_FMEM_BIT] = 1'b1;
            end
            next_s.dref = '{valid: 1'b1, bank: BANK_HIGH, addr: instr.addr[7:0],
                            bit_mask: 4'(4'h1 << instr.bitsel)};
          end
          OP_BIT_PAIRED: begin
            if (instr.addr < PMEM_MIN) begin
              err_set[ERR_PMEM_BIT] = 1'b1;
            end
            next_s.dref = '{valid: 1'b1, bank: BANK_HIGH,
                            addr: {instr.addr[7:2], s.regs[PAIR_HL][3:2]},
                            bit_mask: 4'(4'h1 << s.regs[PAIR_HL][1:0])};
          end
          default: next_s.pc = s.pc + 12'h001;
        endcase
      end
    end

    next_s.err = s.err | err_set;

    // ----------------------------------------------------------------
    // AXI4-Lite write side
    // ----------------------------------------------------------------
    if (awvalid && awready) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    wr_fire = s.aw_held && s.w_held && !s.bvalid;
    if (wr_fire) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      unique case (s.aw_addr)
        ADDR_CTRL: begin
          if (s.w_strb[0]) begin
            next_s.ctrl.run = s.w_data[CTRL_RUN_BIT];
            next_s.ctrl.bank_enable_flag = s.w_data[CTRL_MBE_BIT];
            next_s.ctrl.bank_select_value = s.w_data[CTRL_MBS_LSB +: 4];
          end
          if (s.w_strb[1]) begin
            next_s.ctrl.processor_clock_setting = s.w_data[CTRL_PCS_LSB +: 2];
          end
        end
        // Clear loses to a same-cycle error report
        ADDR_ERR: begin
          if (s.w_strb[0]) begin
            next_s.err = (s.err & ~s.w_data[3:0]) | err_set;
          end
        end
        ADDR_STATUS, ADDR_REGS: next_s.bresp = RESP_OKAY;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read side
    // ----------------------------------------------------------------
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      unique case (araddr)
        ADDR_CTRL: begin
          rd_word[CTRL_RUN_BIT] = s.ctrl.run;
          rd_word[CTRL_MBE_BIT] = s.ctrl.bank_enable_flag;
          rd_word[CTRL_MBS_LSB +: 4] = s.ctrl.bank_select_value;
          rd_word[CTRL_PCS_LSB +: 2] = s.ctrl.processor_clock_setting;
        end
        ADDR_STATUS: begin
          rd_word[STATUS_CY_BIT] = s.carry;
          rd_word[STATUS_CLASS_LSB +: 3] = s.last_class;
          rd_word[STATUS_SKIP_BIT] = s.skip_next;
          rd_word[STATUS_ADJ_LSB +: 3] = s.adj;
          rd_word[STATUS_PC_LSB +: 12] = s.pc;
        end
        ADDR_ERR: rd_word[3:0] = s.err;
        ADDR_REGS: begin
          rd_word[7:0] = s.regs[PAIR_XA];
          rd_word[REGS_HL_LSB +: 8] = s.regs[PAIR_HL];
        end
        default: next_s.rresp = RESP_SLVERR;
      endcase
      next_s.rdata = rd_word;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= CTRL_RESET;
      s.pc <= PC_RESET;
      s.last_class <= STR_NONE;
      s.adj <= ADJ_NONE;
    end else begin
      s <= next_s;
    end
  end

endmodule : skip_and_string_effect_sequencer

// >>> tb/seq_checker_assertions.sv
// Checker of handshake and skip timing at the sequencer ports.
// Assumes the single aclk domain and the op codes of seq_pkg.
`timescale 1ns/1ns
module seq_checker
  import seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [11:0] fetch_pc,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire instr_t instr,
  input wire data_ref_t data_ref,
  input wire logic skip_taken
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take;
  assign take = instr_valid && instr_ready;
  // ----------------
  // Sequences
  // ----------------
  sequence take_long;
    take && (instr.op == OP_JUMP || instr.op == OP_JUMP_WIDE || instr.op == OP_CALL_WIDE);
  endsequence
  sequence jump_kept;
    take && instr.op == OP_JUMP ##1 !skip_taken;
  endsequence
  aw_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write channel open during response");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("read address open during read data");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  b_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  skip_cause_a: assert property (skip_taken |-> $past(take))
    else $error("skip pulse without a taken instruction");
  dref_cause_a: assert property (data_ref.valid |-> $past(take))
    else $error("data reference without a taken instruction");
  pc_hold_a: assert property (!take |=> $stable(fetch_pc))
    else $error("fetch address moved without a take");
  long_skip_a: assert property (take_long ##1 skip_taken |-> !instr_ready)
    else $error("long skip finished in one cycle");
  jump_target_a: assert property (jump_kept |-> fetch_pc == $past(instr.addr))
    else $error("jump target not loaded");
endmodule : seq_checker

bind skip_and_string_effect_sequencer seq_checker chk (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .fetch_pc(fetch_pc), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .instr(instr), .data_ref(data_ref), .skip_taken(skip_taken)
);

// >>> tb/prog_mem.sv
// Program memory model: one decoded instruction per address.
// Assumes the bench fills prog before it releases reset.
`timescale 1ns/1ns
module prog_mem
  import seq_pkg::*;
(
  input wire logic aclk,
  input wire logic slow,
  input wire logic [11:0] fetch_pc,
  input wire logic instr_ready,
  output logic instr_valid,
  output instr_t instr
);
  instr_t prog [32];
  logic ph = 1'b0;
  // Slow mode offers only every other cycle
  always @(posedge aclk) ph <= !ph;
  assign instr_valid = !slow || ph;
  // Idle cycles show a scrambled word, never a stale one
  assign instr = instr_valid ? prog[fetch_pc[4:0]] : instr_t'(~prog[fetch_pc[4:0]]);
endmodule : prog_mem

// >>> tb/skip_and_string_effect_sequencer_test.sv
// Self-checking bench of the sequencer with a program memory model.
// Assumes 100 MHz aclk and the register map of seq_pkg.
`timescale 1ns/1ns
module skip_and_string_effect_sequencer_test;
  import seq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, instr_valid, instr_ready;
  logic carry_flag, skip_taken;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [11:0] fetch_pc;
  logic [3:0] active_data_bank;
  instr_t instr;
  data_ref_t data_ref;
  int n_mismatch = 0, comparisons = 0, n_skip = 0;

  always #5 aclk = ~aclk;
  always @(posedge aclk) if (skip_taken === 1'b1) n_skip <= n_skip + 1;
  // Last data reference seen, for bank and address checks
  data_ref_t last_ref = '0;
  always @(posedge aclk) if (data_ref.valid === 1'b1) last_ref <= data_ref;

  skip_and_string_effect_sequencer DUT (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .fetch_pc(fetch_pc), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .data_ref(data_ref),
    .carry_flag(carry_flag), .active_data_bank(active_data_bank), .skip_taken(skip_taken)
  );
  prog_mem mem (.aclk(aclk), .slow(slow), .fetch_pc(fetch_pc),
    .instr_ready(instr_ready), .instr_valid(instr_valid), .instr(instr));

  // ----------------
  // Shared tasks
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // Response ready held back for st cycles to exercise stalls
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input int st,
                        output logic [1:0] r);
    logic aw_t, w_t, done;
    int t;
    t = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= (st == 0);
    do begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      done = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (!done) bready <= (t >= st);
      t++;
    end while (!done && t < 40);
    if (!done) n_mismatch++;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input int st, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_t, done;
    int t;
    t = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= (st == 0);
    do begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      done = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (!done) rready <= (t >= st);
      t++;
    end while (!done && t < 40);
    if (!done) n_mismatch++;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, 0, d, r);
    check(d, e);
  endtask : expect_reg

  task automatic put(input int a, input op_t op, input logic [11:0] ad, input logic [7:0] im);
    mem.prog[a] = '{op, ad, im, 2'h0, 3'h0, PTR_HL, im};
  endtask : put

  task automatic clear_prog();
    for (int i = 0; i < 32; i++) put(i, OP_NOP, 12'h000, 8'h00);
  endtask : clear_prog

  task automatic run_prog();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    n_skip = 0;
    repeat (30) @(posedge aclk);
  endtask : run_prog

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset();
    run_prog();
    expect_reg(ADDR_CTRL, 32'h0000_0001);
    axi_rd(8'h10, 3, rd, resp);
    check(rd, 32'h0000_0000);
    check(resp, RESP_SLVERR);
    axi_wr(8'h10, 32'h0000_0001, 2, resp);
    check(resp, RESP_SLVERR);
    axi_wr(ADDR_CTRL, 32'h0000_0043, 3, resp);
    check(active_data_bank, 4'h4);
    expect_reg(ADDR_CTRL, 32'h0000_0043);
    axi_wr(ADDR_CTRL, 32'h0000_0001, 0, resp);
    check(active_data_bank, 4'h0);
  endtask : t_reset

  task automatic t_string();
    clear_prog();
    put(0, OP_MOV_A_IMM, 12'h000, 8'h01);
    put(1, OP_MOV_A_IMM, 12'h000, 8'h02);
    put(2, OP_MOV_XA_IMM, 12'h000, 8'h37);
    put(5, OP_MOV_HL_IMM, 12'h000, 8'h55);
    put(7, OP_MOV_HL_IMM, 12'h000, 8'h66);
    put(9, OP_JUMP, 12'h009, 8'h00);
    run_prog();
    expect_reg(ADDR_REGS, 32'h0000_5501);
    clear_prog();
    put(0, OP_JUMP, 12'h003, 8'h00);
    put(3, OP_MOV_A_IMM, 12'h000, 8'h02);
    put(4, OP_MOV_XA_IMM, 12'h000, 8'h37);
    put(6, OP_JUMP, 12'h006, 8'h00);
    run_prog();
    expect_reg(ADDR_REGS, 32'h0000_0002);
  endtask : t_string

  task automatic adjust(input op_t op, input logic [7:0] a, m, n, h,
                        input logic [31:0] e, input logic cy, input int sk);
    clear_prog();
    put(0, OP_MOV_A_IMM, 12'h000, a);
    put(1, op, 12'h000, m);
    put(2, OP_ADD_IMMEDIATE_SKIP_ON_CARRY, 12'h000, n);
    put(3, OP_MOV_HL_IMM, 12'h000, h);
    put(5, OP_JUMP, 12'h005, 8'h00);
    run_prog();
    expect_reg(ADDR_REGS, e);
    check(carry_flag, cy);
    check(n_skip, sk);
  endtask : adjust

  task automatic t_adjust();
    adjust(OP_ADD_WITH_CARRY_OP, 8'h09, 8'h08, 8'h06, 8'h44, 32'h0000_4401, 1'b1, 1);
    adjust(OP_ADD_WITH_CARRY_OP, 8'h02, 8'h03, 8'h0F, 8'h77, 32'h0000_7704, 1'b0, 0);
    adjust(OP_SUBTRACT_WITH_BORROW_OP, 8'h05, 8'h03, 8'h06, 8'h11, 32'h0000_1102, 1'b0, 1);
    adjust(OP_SUBTRACT_WITH_BORROW_OP, 8'h03, 8'h05, 8'h0A, 8'h22, 32'h0000_2208, 1'b1, 0);
  endtask : t_adjust

  task automatic t_long_skip();
    clear_prog();
    slow <= 1'b1;
    put(0, OP_MOV_A_IMM, 12'h000, 8'h0F);
    put(1, OP_ADD_IMMEDIATE_SKIP_ON_CARRY, 12'h000, 8'h01);
    put(2, OP_JUMP_WIDE, 12'h000, 8'h00);
    put(5, OP_MOV_HL_IMM, 12'h000, 8'h33);
    put(7, OP_JUMP, 12'h007, 8'h00);
    run_prog();
    slow <= 1'b0;
    expect_reg(ADDR_REGS, 32'h0000_3300);
    check(n_skip, 1);
    check(fetch_pc, 12'h007);
  endtask : t_long_skip

  task automatic operands(input logic [7:0] t, input logic [11:0] f, p, m,
                          input logic [31:0] e);
    clear_prog();
    put(0, OP_TABLE_CALL, {4'h0, t}, t);
    put(1, OP_BIT_FAST, f, 8'h00);
    put(3, OP_BIT_PAIRED, p, 8'h00);
    put(5, OP_MOV_XA_MEM, m, m[7:0]);
    put(7, OP_JUMP, 12'h007, 8'h00);
    run_prog();
    expect_reg(ADDR_ERR, e);
    check({last_ref.bank, last_ref.addr}, {(m[7:0] > 8'h7F) ? BANK_HIGH : BANK_LOW, m[7:0]});
    axi_wr(ADDR_ERR, 32'h0000_000F, 0, resp);
    expect_reg(ADDR_ERR, 32'h0000_0000);
  endtask : operands

  task automatic t_operands();
    operands(8'h21, 12'hFC0, 12'hF00, 12'h003, 32'h0000_000F);
    operands(8'h20, 12'hFB0, 12'hFC0, 12'h002, 32'h0000_0000);
    operands(8'h80, 12'hFFF, 12'hFBF, 12'h0FE, 32'h0000_0005);
  endtask : t_operands

  initial begin
    t_reset();
    t_string();
    t_adjust();
    t_long_skip();
    t_operands();
    final_report();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    final_report();
  end
endmodule : skip_and_string_effect_sequencer_test
